/* File: pkg/ioxp_regs.vh */
// Constants of the 16-bit quasi-bidirectional expander.
// Assumes inclusion by the core files; definitions only.
`ifndef IOXP_REGS_VH
`define IOXP_REGS_VH

`define IOXP_PORT_W      16
`define IOXP_PORT_RST    16'hFFFF
`define IOXP_GC_ADDR     7'h00
`define IOXP_DEVID_ADDR  7'h7C
`define IOXP_SWRST_BYTE  8'h06
`define IOXP_BYTE_BITS   4'h8
// Upper address nibble picked by which straps sit on a bus line
`define IOXP_HI_NONE     4'h4
`define IOXP_HI_A0       4'h5
`define IOXP_HI_A1       4'h2
`define IOXP_HI_A1A0     4'h3
`define IOXP_HI_A2       4'hC
`define IOXP_HI_A2A0     4'hE
`define IOXP_HI_A2A1     4'hA
`define IOXP_HI_ALL      4'hB

`endif

/* File: core/ioxp_strap_decode.v */
// Strap classifier: each strap is ground, supply, SCL or SDA.
// Assumes all inputs already synchronised to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ioxp_regs.vh"

module ioxp_strap_decode (
    input  wire       core_clk,
    input  wire       rst,
    input  wire [2:0] strap_s,
    input  wire       scl_s,
    output reg  [6:0] addr_r
);
    reg  [2:0] seen_hi_r;
    reg  [2:0] seen_lo_r;
    reg  [2:0] diff_scl_r;
    wire [2:0] on_bus;
    wire [2:0] lvl;
    reg  [3:0] hi_nib;
    reg  [1:0] warm_r;

    // Synchroniser reset values are not pin levels; ignore strap_s until
    // the real level has passed both flops, else a supply strap looks toggled
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            warm_r <= 2'h0;
        else
            warm_r <= {warm_r[0], 1'h1};
    end

    // Per strap: a pin that toggles is on a bus line; one that ever
    // disagrees with SCL must be on SDA
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pin
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    seen_hi_r[g]  <= 1'b0;
                    seen_lo_r[g]  <= 1'b0;
                    diff_scl_r[g] <= 1'b0;
                end else if (warm_r[1]) begin
                    if (strap_s[g])
                        seen_hi_r[g] <= 1'b1;
                    else
                        seen_lo_r[g] <= 1'b1;
                    if (strap_s[g] != scl_s)
                        diff_scl_r[g] <= 1'b1;
                end
            end
            assign on_bus[g] = seen_hi_r[g] & seen_lo_r[g];
            // Low address bit: supply/SDA give one, ground/SCL give zero
            assign lvl[g] = on_bus[g] ? diff_scl_r[g] : seen_hi_r[g];
        end
    endgenerate

    // Address table folded into one nibble choice [RQ9]
    always @* begin
        case (on_bus)
            3'b000:  hi_nib = `IOXP_HI_NONE;  // legacy mapping [RQ13]
            3'b001:  hi_nib = `IOXP_HI_A0;
            3'b010:  hi_nib = `IOXP_HI_A1;
            3'b011:  hi_nib = `IOXP_HI_A1A0;
            3'b100:  hi_nib = `IOXP_HI_A2;
            3'b101:  hi_nib = `IOXP_HI_A2A0;
            3'b110:  hi_nib = `IOXP_HI_A2A1;
            default: hi_nib = `IOXP_HI_ALL;
        endcase
    end

    // Registered so the compare in the serial engine sees a stable value [RQ8]
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            addr_r <= 7'h00;
        else
            addr_r <= {hi_nib, lvl};
    end
endmodule
`default_nettype wire

/* File: core/ioxp_top.v */
// Two-wire bus target driving a 16-bit quasi-bidirectional port.
// Assumes SCL/SDA, straps and port pins are asynchronous to core_clk,
// which must see SCL low and high for at least four cycles each.
// Contract
// RQ1: One 16-bit quasi-bidirectional port controlled and read over the serial target.
// RQ2: Power-on and bus software reset make every port pin an input.
// RQ3: Attention asserts when port input data changes.
// RQ4: Attention is active low, open drain.
// RQ5: Written output values stay latched until overwritten or reset.
// RQ6: Serial target works up to 1 MHz plus Fast and Standard rates.
// RQ7: Master sends 7-bit address and direction after START.
// RQ8: Slave address comes from three strap pins, 64 choices.
// RQ9: Each strap decodes as ground, supply, SCL or SDA.
// RQ10: General Call and Device ID addresses are never own address.
// RQ11: Last bit of first byte: one reads, zero writes.
// RQ12: Identification bytes readable through the Device ID access.
// RQ13: Ground/supply straps give the legacy part's address.
// RQ14: Master takes care with bus-reserved addresses.
// RQ15: Software reset starts with General Call write.
// RQ16: Port bit one releases weak high; zero drives low.
// RQ17: Acknowledge only own strapped address; otherwise leave SDA released. The code also acknowledges General Call and Device ID addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ioxp_regs.vh"

module ioxp_top #(
    parameter [7:0] ID_BYTE0 = 8'h00,  // arbitrary maker code
    parameter [7:0] ID_BYTE1 = 8'h00,  // arbitrary part code
    parameter [7:0] ID_BYTE2 = 8'h00   // arbitrary revision code
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    input  wire [2:0]  slave_strap_pin,
    input  wire [15:0] quasi_io_in,
    output reg  [15:0] quasi_io_out,
    output reg  [15:0] quasi_io_oe,
    output reg         attention_n_out,
    output reg         attention_n_oe
);
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_ADDR = 3'd1;
    localparam [2:0] S_ACK  = 3'd2;
    localparam [2:0] S_WR   = 3'd3;
    localparam [2:0] S_RD   = 3'd4;
    localparam [2:0] S_MACK = 3'd5;

    localparam [1:0] M_PORT = 2'd0;
    localparam [1:0] M_GC   = 2'd1;
    localparam [1:0] M_IDW  = 2'd2;
    localparam [1:0] M_IDR  = 2'd3;

    // Two-flop synchronisers for everything from the pins
    reg  [1:0]  scl_q;
    reg  [1:0]  sda_q;
    reg  [2:0]  strap_q0;
    reg  [2:0]  strap_s;
    reg  [15:0] port_q0;
    reg  [15:0] port_s;
    reg         scl_d;
    reg         sda_d;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_q    <= 2'b11;
            sda_q    <= 2'b11;
            strap_q0 <= 3'b000;
            strap_s  <= 3'b000;
            port_q0  <= `IOXP_PORT_RST;
            port_s   <= `IOXP_PORT_RST;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_q    <= {scl_q[0], scl_in};
            sda_q    <= {sda_q[0], sda_in};
            strap_q0 <= slave_strap_pin;
            strap_s  <= strap_q0;
            port_q0  <= quasi_io_in;
            port_s   <= port_q0;
            scl_d    <= scl_q[1];
            sda_d    <= sda_q[1];
        end
    end

    wire scl_s = scl_q[1];
    wire sda_s = sda_q[1];
    // Bus events seen on the core clock; oversampling covers 1 MHz [RQ6]
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    wire scl_rise  = scl_s & ~scl_d;
    wire scl_fall  = ~scl_s & scl_d;

    wire [6:0] own_addr;

    ioxp_strap_decode u_strap (
        .core_clk (core_clk),
        .rst      (rst),
        .strap_s  (strap_s),
        .scl_s    (scl_s),
        .addr_r   (own_addr)
    );

    reg  [2:0]  state_r;
    reg  [1:0]  mode_r;
    reg  [7:0]  shift_r;
    reg  [3:0]  bit_cnt_r;
    reg         byte_sel_r;
    reg  [1:0]  id_idx_r;
    reg         id_pend_r;
    reg         do_read_r;
    reg         mack_r;
    reg  [15:0] latch_r;
    reg  [15:0] snap_r;
    reg         att_clr;
    reg  [7:0]  tx_byte;

    wire [6:0] rx_addr = shift_r[7:1];
    wire       rx_rw   = shift_r[0];

    // Next byte to send: port snapshot or identification bytes
    always @* begin
        tx_byte = snap_r[7:0];
        if (mode_r == M_IDR) begin
            case (id_idx_r)
                2'd0:    tx_byte = ID_BYTE0;
                2'd1:    tx_byte = ID_BYTE1;
                default: tx_byte = ID_BYTE2;
            endcase
        end else if (byte_sel_r) begin
            tx_byte = snap_r[15:8];
        end
    end

    // Serial target engine; SDA only ever pulled low, never driven high
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r    <= S_IDLE;
            mode_r     <= M_PORT;
            shift_r    <= 8'h00;
            bit_cnt_r  <= 4'h0;
            byte_sel_r <= 1'b0;
            id_idx_r   <= 2'd0;
            id_pend_r  <= 1'b0;
            do_read_r  <= 1'b0;
            mack_r     <= 1'b0;
            sda_oe     <= 1'b0;
            latch_r    <= `IOXP_PORT_RST;  // all inputs at power-on [RQ2]
            snap_r     <= `IOXP_PORT_RST;
            att_clr    <= 1'b0;
        end else begin
            att_clr <= 1'b0;
            if (bus_start) begin
                // Address and direction must follow every START [RQ7]
                state_r    <= S_ADDR;
                bit_cnt_r  <= 4'h0;
                byte_sel_r <= 1'b0;
                id_idx_r   <= 2'd0;
                sda_oe     <= 1'b0;
            end else if (bus_stop) begin
                state_r   <= S_IDLE;
                sda_oe    <= 1'b0;
                id_pend_r <= 1'b0;
            end else begin
                case (state_r)
                    S_ADDR, S_WR: begin
                        if (scl_rise && bit_cnt_r != `IOXP_BYTE_BITS) begin
                            shift_r   <= {shift_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == `IOXP_BYTE_BITS) begin
                            bit_cnt_r <= 4'h0;
                            state_r   <= S_ACK;
                            sda_oe    <= 1'b1;
                            if (state_r == S_ADDR) begin
                                do_read_r <= rx_rw;  // one reads, zero writes [RQ11]
                                if (rx_addr == own_addr) begin
                                    mode_r  <= M_PORT;  // own address only [RQ17]
                                    att_clr <= 1'b1;
                                    if (rx_rw)
                                        snap_r <= port_s;
                                end else if (rx_addr == `IOXP_GC_ADDR && !rx_rw) begin
                                    mode_r <= M_GC;  // reserved, not own [RQ10]
                                end else if (rx_addr == `IOXP_DEVID_ADDR && !rx_rw) begin
                                    mode_r <= M_IDW;
                                end else if (rx_addr == `IOXP_DEVID_ADDR && id_pend_r) begin
                                    mode_r <= M_IDR;  // identification read [RQ12]
                                end else begin
                                    sda_oe  <= 1'b0;  // SDA left released [RQ17]
                                    state_r <= S_IDLE;
                                end
                            end else begin
                                case (mode_r)
                                    M_PORT: begin
                                        // Byte held until rewritten [RQ5]
                                        if (byte_sel_r)
                                            latch_r[15:8] <= shift_r;
                                        else
                                            latch_r[7:0] <= shift_r;
                                        byte_sel_r <= ~byte_sel_r;
                                        att_clr    <= 1'b1;
                                    end
                                    M_GC: begin
                                        if (shift_r == `IOXP_SWRST_BYTE)
                                            latch_r <= `IOXP_PORT_RST;  // [RQ2]
                                        else begin
                                            sda_oe  <= 1'b0;
                                            state_r <= S_IDLE;
                                        end
                                    end
                                    default: begin
                                        if (rx_addr == own_addr)
                                            id_pend_r <= 1'b1;
                                        else begin
                                            sda_oe  <= 1'b0;
                                            state_r <= S_IDLE;
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            if (do_read_r) begin
                                shift_r <= tx_byte;
                                sda_oe  <= ~tx_byte[7];
                                state_r <= S_RD;
                            end else begin
                                sda_oe  <= 1'b0;
                                state_r <= S_WR;
                            end
                        end
                    end
                    S_RD: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_r == `IOXP_BYTE_BITS) begin
                                sda_oe     <= 1'b0;
                                bit_cnt_r  <= 4'h0;
                                state_r    <= S_MACK;
                                byte_sel_r <= ~byte_sel_r;
                                if (id_idx_r != 2'd2)
                                    id_idx_r <= id_idx_r + 2'd1;
                            end else begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_oe  <= ~shift_r[6];
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            mack_r <= ~sda_s;
                        end else if (scl_fall) begin
                            if (mack_r) begin
                                if (mode_r == M_PORT && !byte_sel_r)
                                    snap_r <= port_s;  // fresh pair each two bytes
                                shift_r <= tx_byte;
                                sda_oe  <= ~tx_byte[7];
                                state_r <= S_RD;
                            end else begin
                                state_r <= S_IDLE;
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Port drive: one released weak high, zero pulled low [RQ16] [RQ1]
    genvar g;
    generate
        for (g = 0; g < `IOXP_PORT_W; g = g + 1) begin : g_port
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    quasi_io_out[g] <= 1'b0;
                    quasi_io_oe[g]  <= 1'b0;
                end else begin
                    quasi_io_out[g] <= 1'b0;
                    quasi_io_oe[g]  <= ~latch_r[g];
                end
            end
        end
    endgenerate

    // Attention: set by any change of the synced inputs, cleared on a port
    // access; a change in the clearing cycle still wins [RQ3] [RQ4]
    reg  [15:0] port_prev_r;
    wire        att_set = (port_s != port_prev_r);
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_prev_r     <= `IOXP_PORT_RST;  // Idle level, so no false edge
            attention_n_out <= 1'b0;
            attention_n_oe  <= 1'b0;
            sda_out         <= 1'b0;
        end else begin
            port_prev_r     <= port_s;
            attention_n_out <= 1'b0;
            sda_out         <= 1'b0;
            if (att_set)
                attention_n_oe <= 1'b1;
            else if (att_clr)
                attention_n_oe <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: core/ioxp_spare_none.v */
// Intentionally holds no logic.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: bench/ioxp_checker.sv */
// Port checker for the expander top: pins, reset and bus timing.
// Assumes SCL low and high last at least four core_clk cycles each.
`timescale 1ns/1ps
`default_nettype none
module ioxp_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        scl_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic [15:0] quasi_io_out,
    input wire logic [15:0] quasi_io_oe,
    input wire logic        attention_n_out,
    input wire logic        attention_n_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Open-drain pins may only ever sink
    a_sda_sink_only: assert property (sda_out == 1'b0)
        else $error("sda output level not low");
    a_port_sink_only: assert property (quasi_io_out == 16'h0000)
        else $error("port output level not low");
    a_attn_sink_only: assert property (attention_n_out == 1'b0)
        else $error("attention output level not low");
    // First edge after reset: every pin released
    a_reset_all_inputs: assert property ($fell(rst) |->
        quasi_io_oe == 16'h0000 && !attention_n_oe && !sda_oe)
        else $error("pin driven right after reset");
    // SDA may only move while SCL is low, well after its fall
    a_sda_moves_low: assert property ($changed(sda_oe) |->
        !scl_in && !$past(scl_in, 2))
        else $error("sda moved outside scl low");
    a_sda_bit_holds: assert property ($rose(sda_oe) |=> sda_oe [*7])
        else $error("sda pull shorter than a bit");
    // Latches change and attention clears only while the target acknowledges
    a_port_moves_low: assert property ($changed(quasi_io_oe) |-> sda_oe)
        else $error("port changed outside an ack");
    a_attn_clear_ack: assert property ($fell(attention_n_oe) |-> sda_oe)
        else $error("attention cleared outside ack");
endmodule
bind ioxp_top ioxp_checker ioxp_checker_inst (
    .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .quasi_io_out(quasi_io_out), .quasi_io_oe(quasi_io_oe),
    .attention_n_out(attention_n_out), .attention_n_oe(attention_n_oe));
`default_nettype wire

/* File: bench/ioxp_i2c_master.sv */
// Behavioural bus master driving SCL and pulling SDA.
// Assumes SDA pull-up outside; SCL stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module ioxp_i2c_master (
    output logic      scl_o,
    output logic      sda_oe_o,
    input  wire logic sda_i
);
    localparam time Q = 80; // Quarter bit; SCL low and high 4 core cycles each
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Start or repeated start; SDA falls while SCL is high
    task automatic start();
        #Q sda_oe_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_oe_o = 1'b1;
        #Q scl_o = 1'b0;
    endtask
    task automatic stop();
        #Q sda_oe_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_oe_o = 1'b0;
        #Q;
    endtask
    // Data set mid SCL low; a late ack release still settles before SCL rises
    task automatic bit_out(input logic b);
        #Q sda_oe_o = !b;
        #Q scl_o = 1'b1;
        #(2 * Q) scl_o = 1'b0;
    endtask
    task automatic bit_in(output logic b);
        #Q sda_oe_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q b = sda_i;
        #Q scl_o = 1'b0;
    endtask
    // Byte out, MSB first, then the target's ack bit
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(b);
        ack = !b;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(last);
    endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench: master model, pin resolution, strap drive.
// Assumes ioxp_top with the checker bound; no strong-high pin drive.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk, rst;
    logic [15:0] ext_low_r;
    logic [1:0] strap_mode [3]; // 0 ground, 1 supply, 2 SCL, 3 SDA
    logic [2:0] strap_w;
    int fail_count, checks, cyc;
    wire scl_w, m_sda_oe, sda_out, sda_oe, att_n_out, att_n_oe;
    wire [15:0] io_out, io_oe;
    wire sda_w = !(sda_oe || m_sda_oe);
    wire [15:0] io_w = ~(io_oe | ext_low_r);
    wire att_w = !att_n_oe;
    // Straps may follow the live bus lines
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            strap_w[i] = strap_mode[i] == 2'd0 ? 1'b0 : strap_mode[i] == 2'd1 ? 1'b1 :
                         strap_mode[i] == 2'd2 ? scl_w : sda_w;
        end
    end
    ioxp_top #(.ID_BYTE0(8'h3C), .ID_BYTE1(8'h5A), .ID_BYTE2(8'h01)) ioxp_top_inst (
        .core_clk(core_clk), .rst(rst), .scl_in(scl_w), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .slave_strap_pin(strap_w),
        .quasi_io_in(io_w), .quasi_io_out(io_out), .quasi_io_oe(io_oe),
        .attention_n_out(att_n_out), .attention_n_oe(att_n_oe));
    ioxp_i2c_master ioxp_i2c_master_inst (.scl_o(scl_w), .sda_oe_o(m_sda_oe), .sda_i(sda_w));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge core_clk) rst = 1'b1;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    // Start plus address byte
    task automatic addr(input logic [6:0] a, input logic rd, output logic ack);
        ioxp_i2c_master_inst.start();
        ioxp_i2c_master_inst.send({a, rd}, ack);
    endtask
    task automatic wr16(input logic [6:0] a, input logic [15:0] d);
        logic k0, k1, k2;
        addr(a, 1'b0, k0);
        ioxp_i2c_master_inst.send(d[7:0], k1);
        ioxp_i2c_master_inst.send(d[15:8], k2);
        ioxp_i2c_master_inst.stop();
        check({13'h0, k0, k1, k2}, 16'h0007);
    endtask
    task automatic rd16(input logic [6:0] a, output logic [15:0] d);
        logic k;
        addr(a, 1'b1, k);
        check({15'h0, k}, 16'h0001);
        ioxp_i2c_master_inst.recv(1'b0, d[7:0]);
        ioxp_i2c_master_inst.recv(1'b1, d[15:8]);
        ioxp_i2c_master_inst.stop();
    endtask
    task automatic t_write_read();
        logic [15:0] d;
        check(io_oe, 16'h0000);
        check({15'h0, att_w}, 16'h0001);
        wr16(7'h20, 16'h0FA5);
        check(io_oe, 16'hF05A);
        @(negedge core_clk) ext_low_r = 16'h0100;
        rd16(7'h20, d);
        check(d, 16'h0EA5);
        check(io_oe, 16'hF05A);
        rd16(7'h20, d);
        check({15'h0, att_n_oe}, 16'h0000);
        @(negedge core_clk) ext_low_r = 16'h0101;
        repeat (6) @(negedge core_clk);
        check({14'h0, att_n_oe, att_w}, 16'h0002);
        rd16(7'h20, d);
        check(d, 16'h0EA4);
        check({15'h0, att_n_oe}, 16'h0000);
    endtask
    // Foreign address, then an ID read with no ID write first
    task automatic t_refuse();
        logic k;
        addr(7'h21, 1'b0, k);
        ioxp_i2c_master_inst.stop();
        check({15'h0, k}, 16'h0000);
        addr(7'h7C, 1'b1, k);
        ioxp_i2c_master_inst.stop();
        check({15'h0, k}, 16'h0000);
    endtask
    task automatic t_devid();
        logic k0, k1, k2;
        logic [7:0] b0, b1, b2;
        addr(7'h7C, 1'b0, k0);
        ioxp_i2c_master_inst.send(8'h40, k1);
        addr(7'h7C, 1'b1, k2);
        ioxp_i2c_master_inst.recv(1'b0, b0);
        ioxp_i2c_master_inst.recv(1'b0, b1);
        ioxp_i2c_master_inst.recv(1'b1, b2);
        ioxp_i2c_master_inst.stop();
        check({13'h0, k0, k1, k2}, 16'h0007);
        check({b1, b0}, 16'h5A3C);
        check({8'h0, b2}, 16'h0001);
    endtask
    task automatic t_swreset();
        logic k;
        wr16(7'h20, 16'h0000);
        check(io_oe, 16'hFFFF);
        addr(7'h00, 1'b0, k);
        ioxp_i2c_master_inst.send(8'h06, k);
        ioxp_i2c_master_inst.stop();
        check(io_oe, 16'h0000);
    endtask
    // Strapping table: mode of AD2, AD1, AD0 and the 7-bit address
    task automatic t_straps();
        logic [5:0] mode [4] = '{6'b00_00_00, 6'b00_10_00, 6'b01_11_01, 6'b01_01_01};
        logic [6:0] exp [4] = '{7'h20, 7'h10, 7'h17, 7'h27};
        logic k;
        logic [15:0] d;
        for (int i = 0; i < 4; i++) begin
            {strap_mode[2], strap_mode[1], strap_mode[0]} = mode[i];
            do_reset();
            addr(7'h55, 1'b0, k); // Unreserved code; exercises the straps
            ioxp_i2c_master_inst.stop();
            rd16(exp[i], d);
            addr(exp[i] ^ 7'h01, 1'b1, k);
            ioxp_i2c_master_inst.stop();
            check({15'h0, k}, 16'h0000);
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = !core_clk;
    end
    // Hang guard well above the expected run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        rst = 1'b1;
        ext_low_r = 16'h0000;
        strap_mode = '{2'd0, 2'd0, 2'd0};
        fail_count = 0;
        checks = 0;
        cyc = 0;
        do_reset();
        t_write_read();
        t_refuse();
        t_devid();
        t_swreset();
        t_straps();
        print_verdict();
    end
endmodule
`default_nettype wire
